//--- dv/tb_idse_exec.sv
// self-checking bench of the step/shift executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) \
  begin compares++; if ((act) !== (exp)) begin errors++; \
  $display("ERROR %0t: got %h want %h", $time, (act), (exp)); end end

module tb_idse_exec
  import idse_pkg::*;
;
  localparam int WW    = 4;
  localparam int LIMIT = 10000;

  logic              mclk;
  logic              arst_n;
  logic              start;
  idse_op_t          op;
  idse_width_t       width;
  logic [1:0]        step_sel;
  logic              src_mode;
  logic [31:0]       operand;
  idse_loc_t         loc;
  logic              dir_short;
  logic [WW-1:0]     wait_n;
  logic              busy;
  logic              done;
  logic [2:0]        bytes;
  logic [7:0]        states;
  logic [31:0]       result;
  logic              carry;
  logic              carry_upd;
  int                errors;
  int                compares;
  int                cycles = 0;

  idse_exec #(.WAIT_W(WW)) idse_exec_i (
    .i_mclk(mclk), .i_arst_n(arst_n), .i_start(start), .i_op(op), .i_width(width),
    .i_step_sel(step_sel), .i_src_mode(src_mode), .i_operand(operand), .i_loc(loc),
    .i_dir_short(dir_short), .i_wait_n(wait_n), .o_busy(busy), .o_done(done),
    .o_bytes(bytes), .o_states(states), .o_result(result), .o_carry_flag(carry),
    .o_carry_upd(carry_upd)
  );

  always #12.5 mclk = ~mclk;

  // ==========================================================
  // expected lengths and counts
  function automatic logic [31:0] msk(idse_width_t w);
    return (w == IDSE_W_BYTE) ? 32'h0000_00ff : (w == IDSE_W_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
  endfunction

  function automatic logic [2:0] exp_by(idse_op_t o, idse_width_t w, logic sm);
    case (o)
      IDSE_OP_STEP_UP_DIR, IDSE_OP_STEP_DOWN_DIR: return 3'h2;
      IDSE_OP_STEP_UP_IND, IDSE_OP_STEP_DOWN_IND: return sm ? 3'h2 : 3'h1;
      IDSE_OP_SWAP_NIBBLE:                        return 3'h1;
      default:                                    return sm ? 3'h2 : 3'h3;
    endcase
  endfunction

  function automatic logic [7:0] exp_st(idse_op_t o, idse_width_t w, logic sm, idse_loc_t l,
                                        logic sh, logic [WW-1:0] n);
    logic [7:0] b;
    logic [7:0] a;
    a = 8'h00;
    case (l)
      IDSE_LOC_IO:     a = sh ? 8'h01 : 8'h02;
      IDSE_LOC_PERIPH: a = sh ? 8'h02 : 8'h03;
      IDSE_LOC_EXT:    a = (w == IDSE_W_BYTE) ? 8'(n) + 8'h02 : 8'h02 * (8'(n) + 8'h02);
      default:         a = 8'h00;
    endcase
    case (o)
      IDSE_OP_STEP_UP_REG, IDSE_OP_STEP_DOWN_REG:
        if (w != IDSE_W_DWORD) b = sm ? 8'h01 : 8'h02;
        else if (o == IDSE_OP_STEP_UP_REG) b = sm ? 8'h03 : 8'h04;
        else b = sm ? 8'h04 : 8'h05;
      IDSE_OP_STEP_UP_DIR, IDSE_OP_STEP_DOWN_DIR: b = 8'h02 + a;
      IDSE_OP_STEP_UP_IND, IDSE_OP_STEP_DOWN_IND: b = (sm ? 8'h04 : 8'h03) + a;
      IDSE_OP_SWAP_NIBBLE: b = 8'h02;
      default: b = sm ? 8'h01 : 8'h02;
    endcase
    return b;
  endfunction

  // ==========================================================
  // one request, timed and length-checked
  task automatic run_op(input idse_op_t o, input idse_width_t w, input logic [1:0] s,
                        input logic sm, input logic [31:0] v, input idse_loc_t l,
                        input logic sh, input logic [WW-1:0] n,
                        output logic [31:0] r, output logic c, output logic u);
    logic [8:0] k;
    op = o; width = w; step_sel = s; src_mode = sm;
    operand = v; loc = l; dir_short = sh; wait_n = n;
    start = 1'h1;
    @(posedge mclk);
    #1 start = 1'h0;
    `CHK(busy, 1'h1)
    `CHK(bytes, exp_by(o, w, sm))
    `CHK(states, exp_st(o, w, sm, l, sh, n))
    k = 9'h000;
    do begin
      @(posedge mclk);
      #1 k++;
    end while (done !== 1'h1 && k < 9'h12c);
    `CHK(k, {1'h0, exp_st(o, w, sm, l, sh, n)})
    `CHK(busy, 1'h0)
    r = result; c = carry; u = carry_upd;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reg_step();
    logic [31:0] r, v, e, st;
    logic c, u, pc;
    for (int m = 0; m < 2; m++) for (int wi = 0; wi < 3; wi++)
    for (int d = 0; d < 2; d++) for (int s = 0; s < 4; s++) begin
      v  = d ? 32'h0000_0001 : 32'hffff_fffe;
      st = (s == 1) ? 32'h2 : (s == 2) ? 32'h4 : 32'h1;
      e  = (d ? v - st : v + st) & msk(idse_width_t'(wi));
      pc = carry;
      run_op(d ? IDSE_OP_STEP_DOWN_REG : IDSE_OP_STEP_UP_REG, idse_width_t'(wi), 2'(s),
             1'(m), v, IDSE_LOC_EXT, 1'h0, 4'hf, r, c, u);
      case (wi)
        0: `CHK(r, e)
        1: `CHK(r, e)
        default: `CHK(r, e)
      endcase
      `CHK({c, u}, {pc, 1'h0})
    end
  endtask

  task automatic t_direct();
    logic [31:0] r;
    logic c, u;
    for (int m = 0; m < 2; m++) for (int d = 0; d < 2; d++)
    for (int l = 0; l < 3; l++) for (int sh = 0; sh < 2; sh++) begin
      run_op(d ? IDSE_OP_STEP_DOWN_DIR : IDSE_OP_STEP_UP_DIR, IDSE_W_BYTE, 2'h0, 1'(m),
             32'h0000_00ff, idse_loc_t'(l), 1'(sh), 4'h0, r, c, u);
      `CHK(r, d ? 32'h0000_00fe : 32'h0000_0000)
      if (sh) `CHK(states, 8'h02 + 8'(l))
      else `CHK(states, (l == 0) ? 8'h02 : 8'h03 + 8'(l))
    end
  endtask

  task automatic t_indirect();
    logic [31:0] r;
    logic [7:0] n8;
    logic c, u;
    for (int m = 0; m < 2; m++) for (int wi = 0; wi < 2; wi++)
    for (int x = 0; x < 2; x++) for (int n = 0; n < 16; n += 15) begin
      n8 = 8'(n);
      run_op(IDSE_OP_STEP_UP_IND, idse_width_t'(wi), 2'h0, 1'(m), 32'h0000_00ff,
             x ? IDSE_LOC_EXT : IDSE_LOC_RAM, 1'h0, 4'(n), r, c, u);
      `CHK(r, wi ? 32'h0000_0100 : 32'h0000_0000)
      if (x && wi == 0) `CHK(states, (m ? 8'h04 : 8'h03) + n8 + 8'h02)
      if (x && wi == 1) `CHK(states, (m ? 8'h04 : 8'h03) + 8'h02 * (n8 + 8'h02))
    end
    run_op(IDSE_OP_STEP_DOWN_IND, IDSE_W_BYTE, 2'h0, 1'h1, 32'h0000_0000, IDSE_LOC_RAM,
           1'h0, 4'h0, r, c, u);
    `CHK(r, 32'h0000_00ff)
  endtask

  task automatic t_shift();
    logic [31:0] r, x, e;
    logic c, u, ec;
    int hb;
    for (int oi = 6; oi < 9; oi++) for (int wi = 0; wi < 2; wi++)
    for (int m = 0; m < 2; m++) for (int p = 0; p < 2; p++) begin
      x  = (p ? 32'h0000_4242 : 32'h0000_8181) & msk(idse_width_t'(wi));
      hb = wi ? 15 : 7;
      case (oi)
        6:       begin e = (x << 1) & msk(idse_width_t'(wi)); ec = x[hb]; end
        7:       begin e = (x >> 1) | (32'(x[hb]) << hb); ec = x[0]; end
        default: begin e = x >> 1; ec = x[0]; end
      endcase
      run_op(idse_op_t'(oi), idse_width_t'(wi), 2'h0, 1'(m), x, IDSE_LOC_RAM, 1'h0, 4'h0,
             r, c, u);
      case (oi)
        6: `CHK({r, c, u}, {e, ec, 1'h1})
        7: `CHK({r, c, u}, {e, ec, 1'h1})
        default: `CHK({r, c, u}, {e, ec, 1'h1})
      endcase
      if (oi == 6 && wi == 1) `CHK(states, m ? 8'h01 : 8'h02)
    end
  endtask

  task automatic t_swap();
    logic [31:0] r;
    logic c, u, pc;
    for (int m = 0; m < 2; m++) begin
      pc = carry;
      run_op(IDSE_OP_SWAP_NIBBLE, IDSE_W_BYTE, 2'h0, 1'(m), 32'h0000_00a5, IDSE_LOC_RAM,
             1'h0, 4'h0, r, c, u);
      `CHK({r, c, u}, {32'h0000_005a, pc, 1'h0})
    end
  endtask

  // reset in mid-run, then a fresh request
  task automatic t_reset();
    logic [31:0] r;
    logic c, u;
    op = IDSE_OP_STEP_UP_IND; width = IDSE_W_WORD; src_mode = 1'h0;
    operand = 32'h0000_1234; loc = IDSE_LOC_EXT; wait_n = 4'hf;
    start = 1'h1;
    @(posedge mclk);
    #1 start = 1'h0;
    repeat (3) @(posedge mclk);
    #1 arst_n = 1'h0;
    #1 `CHK({busy, done, carry_upd, bytes, states, result, carry}, 47'h0)
    repeat (2) @(posedge mclk);
    #1 arst_n = 1'h1;
    `CHK({busy, done}, 2'h0)
    run_op(IDSE_OP_STEP_DOWN_REG, IDSE_W_BYTE, 2'h1, 1'h1, 32'h0000_0010, IDSE_LOC_RAM,
           1'h0, 4'h0, r, c, u);
    `CHK(r, 32'h0000_000e)
  endtask

  // ==========================================================
  // verdict and hang guard
  task automatic conclude();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      conclude();
    end
  end

  initial begin
    mclk = 1'h0; arst_n = 1'h0; start = 1'h0; op = IDSE_OP_STEP_UP_REG;
    width = IDSE_W_BYTE; step_sel = 2'h0; src_mode = 1'h0; operand = 32'h0;
    loc = IDSE_LOC_RAM; dir_short = 1'h0; wait_n = 4'h0;
    errors = 0; compares = 0;
    repeat (20) @(posedge mclk);
    #1 arst_n = 1'h1;
    `CHK({busy, done}, 2'h0)
    t_reg_step();
    t_direct();
    t_indirect();
    t_shift();
    t_swap();
    t_reset();
    conclude();
  end
endmodule // tb_idse_exec

`undef CHK
`default_nettype wire

//--- rtl/idse_alu.sv
// operand datapath of the step/shift executor
`timescale 1ns/1ps
`default_nettype none
`include "idse_regs.svh"

module idse_alu
  import idse_pkg::*;
(
  // operation
  input  wire idse_op_t    i_op,
  input  wire idse_width_t i_width,
  input  wire logic [1:0]  i_step_sel,
  input  wire logic [31:0] i_operand,
  // result
  output logic [31:0]      o_result,
  output logic             o_carry
);

  logic [31:0] amt;
  logic [31:0] raw;
  logic        wide;

  always_comb begin
    wide = (i_width != IDSE_W_BYTE);
    case (i_step_sel)
      `IDSE_STEP_SEL_2: amt = 32'h0000_0002;
      `IDSE_STEP_SEL_4: amt = 32'h0000_0004;
      default:          amt = 32'h0000_0001;
    endcase
    raw     = i_operand;
    o_carry = 1'b0;
    case (i_op)
      IDSE_OP_STEP_UP_REG,
      IDSE_OP_STEP_UP_DIR,
      IDSE_OP_STEP_UP_IND:   raw = i_operand + amt;
      IDSE_OP_STEP_DOWN_REG,
      IDSE_OP_STEP_DOWN_DIR,
      IDSE_OP_STEP_DOWN_IND: raw = i_operand - amt;
      // RULE_09 RULE_10 left shift
      IDSE_OP_SHIFT_LEFT: begin
        raw     = {i_operand[30:0], 1'b0};
        o_carry = wide ? i_operand[15] : i_operand[7];
      end
      // RULE_11 arithmetic right
      IDSE_OP_SHIFT_RIGHT_ARITH: begin
        raw     = wide ? {16'h0000, i_operand[15], i_operand[15:1]}
                       : {24'h00_0000, i_operand[7], i_operand[7:1]};
        o_carry = i_operand[0];
      end
      // RULE_12 logical right
      IDSE_OP_SHIFT_RIGHT_LOGIC: begin
        raw     = wide ? {17'h0_0000, i_operand[15:1]}
                       : {25'h000_0000, i_operand[7:1]};
        o_carry = i_operand[0];
      end
      // RULE_13 nibble swap
      IDSE_OP_SWAP_NIBBLE: raw = {24'h00_0000, i_operand[3:0], i_operand[7:4]};
      default: raw = i_operand;
    endcase
    case (i_width)
      IDSE_W_BYTE:  o_result = {24'h00_0000, raw[7:0]};
      IDSE_W_WORD:  o_result = {16'h0000, raw[15:0]};
      default:      o_result = raw;
    endcase
  end

endmodule // idse_alu

`default_nettype wire

//--- rtl/idse_exec.sv
// step, shift and nibble-swap executor with state-count timing
//
// Operation
// RULE_01: byte register steps 1/2/4, 3b2s or 2b1s
// RULE_02: word register step, 3b2s or 2b1s
// RULE_03: dword step 3b/2b, up 4/3, down 5/4
// RULE_04: direct step 2b2s; io +2, periph +3
// RULE_05: indirect step 1b3s or 2b4s
// RULE_06: external byte access adds N+2 states
// RULE_07: external word access adds 2(N+2) states
// RULE_08: short direct form: io +1, periph +2
// RULE_09: byte left shift, carry from top bit
// RULE_10: word left shift, same lengths and counts
// RULE_11: arithmetic right keeps top bit, carry bit0
// RULE_12: logical right clears top, carry bit0
// RULE_13: accumulator nibble swap, 1 byte 2 states
// RULE_14: total is base plus all additions
`timescale 1ns/1ps
`default_nettype none
`include "idse_regs.svh"

module idse_exec
  import idse_pkg::*;
#(
  parameter int WAIT_W = 4
)(
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_arst_n,
  // request
  input  wire logic              i_start,
  input  wire idse_op_t          i_op,
  input  wire idse_width_t       i_width,
  input  wire logic [1:0]        i_step_sel,
  input  wire logic              i_src_mode,
  input  wire logic [31:0]       i_operand,
  // operand location
  input  wire idse_loc_t         i_loc,
  input  wire logic              i_dir_short,
  input  wire logic [WAIT_W-1:0] i_wait_n,
  // status
  output logic                   o_busy,
  output logic                   o_done,
  output logic [2:0]             o_bytes,
  output logic [7:0]             o_states,
  // result
  output logic [31:0]            o_result,
  output logic                   o_carry_flag,
  output logic                   o_carry_upd
);

  localparam idse_exec_st_t ST_RST = '{
    state: IDSE_ST_IDLE, cnt: 8'h00, op: IDSE_OP_STEP_UP_REG,
    width: IDSE_W_BYTE, step_sel: 2'h0, opnd: 32'h0000_0000,
    bytes: 3'h0, states: 8'h00, result: 32'h0000_0000,
    carry: 1'b0, carry_upd: 1'b0, done: 1'b0};

  idse_exec_st_t st_ff;
  idse_exec_st_t nxt_st;
  logic [2:0]    base_b;
  logic [7:0]    base_s;
  logic [7:0]    extra_s;
  logic [7:0]    ext_b;
  logic [7:0]    total_s;
  logic [31:0]   alu_res;
  logic          alu_cy;
  logic          take;
  logic          is_shift;

  // ==========================================================
  // datapath
  idse_alu u_alu (
    .i_op       (st_ff.op),
    .i_width    (st_ff.width),
    .i_step_sel (st_ff.step_sel),
    .i_operand  (st_ff.opnd),
    .o_result   (alu_res),
    .o_carry    (alu_cy)
  );

  // ==========================================================
  // base lengths and state counts
  always_comb begin
    base_b = i_src_mode ? `IDSE_B_REG_SRC : `IDSE_B_REG_BIN;
    base_s = i_src_mode ? `IDSE_S_REG_SRC : `IDSE_S_REG_BIN;
    case (i_op)
      // RULE_01 RULE_02 RULE_03 register step
      IDSE_OP_STEP_UP_REG: begin
        if (i_width == IDSE_W_DWORD) begin
          base_s = i_src_mode ? `IDSE_S_DUP_SRC : `IDSE_S_DUP_BIN;
        end
      end
      IDSE_OP_STEP_DOWN_REG: begin
        if (i_width == IDSE_W_DWORD) begin
          base_s = i_src_mode ? `IDSE_S_DDN_SRC : `IDSE_S_DDN_BIN;
        end
      end
      // RULE_04 direct step
      IDSE_OP_STEP_UP_DIR,
      IDSE_OP_STEP_DOWN_DIR: begin
        base_b = `IDSE_B_DIR;
        base_s = `IDSE_S_DIR;
      end
      // RULE_05 indirect step
      IDSE_OP_STEP_UP_IND,
      IDSE_OP_STEP_DOWN_IND: begin
        base_b = i_src_mode ? `IDSE_B_IND_SRC : `IDSE_B_IND_BIN;
        base_s = i_src_mode ? `IDSE_S_IND_SRC : `IDSE_S_IND_BIN;
      end
      // RULE_13 swap timing
      IDSE_OP_SWAP_NIBBLE: begin
        base_b = `IDSE_B_SWAP;
        base_s = `IDSE_S_SWAP;
      end
      default: begin
        base_b = i_src_mode ? `IDSE_B_REG_SRC : `IDSE_B_REG_BIN;
      end
    endcase
  end

  // ==========================================================
  // location additions
  always_comb begin
    // RULE_06 external byte
    ext_b   = 8'(i_wait_n) + `IDSE_EXT_BASE;
    extra_s = 8'h00;
    case (i_op)
      IDSE_OP_STEP_UP_DIR,
      IDSE_OP_STEP_DOWN_DIR: begin
        // RULE_08 short direct form
        if (i_loc == IDSE_LOC_IO) begin
          extra_s = i_dir_short ? `IDSE_ADD_IO_SHORT : `IDSE_ADD_IO_LONG;
        end else if (i_loc == IDSE_LOC_PERIPH) begin
          extra_s = i_dir_short ? `IDSE_ADD_PER_SHORT : `IDSE_ADD_PER_LONG;
        end
      end
      IDSE_OP_STEP_UP_IND,
      IDSE_OP_STEP_DOWN_IND: begin
        // RULE_07 external word
        if (i_loc == IDSE_LOC_EXT) begin
          extra_s = (i_width == IDSE_W_BYTE) ? ext_b : {ext_b[6:0], 1'b0};
        end
      end
      default: extra_s = 8'h00;
    endcase
    // RULE_14 total count
    total_s = base_s + extra_s;
  end

  // ==========================================================
  // sequencer
  assign take     = i_start && (st_ff.state == IDSE_ST_IDLE);
  assign is_shift = (st_ff.op == IDSE_OP_SHIFT_LEFT) ||
                    (st_ff.op == IDSE_OP_SHIFT_RIGHT_ARITH) ||
                    (st_ff.op == IDSE_OP_SHIFT_RIGHT_LOGIC);

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.done      = 1'b0;
    nxt_st.carry_upd = 1'b0;
    case (st_ff.state)
      IDSE_ST_IDLE: begin
        if (i_start) begin
          nxt_st.state    = IDSE_ST_RUN;
          nxt_st.op       = i_op;
          nxt_st.width    = (i_op == IDSE_OP_SWAP_NIBBLE) ? IDSE_W_BYTE : i_width;
          nxt_st.step_sel = i_step_sel;
          nxt_st.opnd     = i_operand;
          nxt_st.bytes    = base_b;
          nxt_st.states   = total_s;
          nxt_st.cnt      = total_s;
        end
      end
      IDSE_ST_RUN: begin
        nxt_st.cnt = st_ff.cnt - 8'h01;
        // RULE_14 finish after count
        if (st_ff.cnt == 8'h01) begin
          nxt_st.state  = IDSE_ST_IDLE;
          nxt_st.done   = 1'b1;
          nxt_st.result = alu_res;
          if (is_shift) begin
            nxt_st.carry     = alu_cy;
            nxt_st.carry_upd = 1'b1;
          end
        end
      end
      default: nxt_st = ST_RST;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_busy       = st_ff.state[1];
  assign o_done       = st_ff.done;
  assign o_bytes      = st_ff.bytes;
  assign o_states     = st_ff.states;
  assign o_result     = st_ff.result;
  assign o_carry_flag = st_ff.carry;
  assign o_carry_upd  = st_ff.carry_upd;

  // ==========================================================
  // checks
  logic [7:0] h_cyc_ff;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      h_cyc_ff <= 8'h00;
    end else if (take) begin
      h_cyc_ff <= 8'h00;
    end else if (o_busy) begin
      h_cyc_ff <= h_cyc_ff + 8'h01;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  AST_BYTE_STEP: assert property ( // RULE_01
    take && i_op == IDSE_OP_STEP_UP_REG && i_width == IDSE_W_BYTE && i_src_mode
      && i_step_sel == `IDSE_STEP_SEL_4
    |=> o_bytes == 3'h2 && o_states == 8'h01
    ##1 o_done && o_result[7:0] == 8'($past(i_operand[7:0], 2) + 8'h04))
    else $error("byte step wrong");

  AST_WORD_STEP: assert property ( // RULE_02
    take && i_op == IDSE_OP_STEP_DOWN_REG && i_width == IDSE_W_WORD && !i_src_mode
    |=> o_bytes == 3'h3 && o_states == 8'h02 ##1 !o_done ##1 o_done)
    else $error("word step timing wrong");

  AST_DWORD_DOWN: assert property ( // RULE_03
    take && i_op == IDSE_OP_STEP_DOWN_REG && i_width == IDSE_W_DWORD
    |=> o_states == ($past(i_src_mode) ? 8'h04 : 8'h05))
    else $error("dword down count wrong");

  AST_DIR_IO: assert property ( // RULE_04
    take && i_op == IDSE_OP_STEP_UP_DIR && i_loc == IDSE_LOC_IO && !i_dir_short
    |=> o_bytes == 3'h2 && o_states == 8'h04 ##4 o_done)
    else $error("direct io step wrong");

  AST_IND_SRC: assert property ( // RULE_05
    take && i_op == IDSE_OP_STEP_DOWN_IND && i_loc == IDSE_LOC_RAM && i_src_mode
    |=> o_bytes == 3'h2 && o_states == 8'h04)
    else $error("indirect step wrong");

  AST_EXT_BYTE: assert property ( // RULE_06
    take && i_op == IDSE_OP_STEP_UP_IND && i_loc == IDSE_LOC_EXT
      && i_width == IDSE_W_BYTE && !i_src_mode
    |=> o_states == 8'($past(i_wait_n)) + 8'h05)
    else $error("external byte wait wrong");

  AST_EXT_WORD: assert property ( // RULE_07
    take && i_op == IDSE_OP_STEP_UP_IND && i_loc == IDSE_LOC_EXT
      && i_width == IDSE_W_WORD && i_src_mode
    |=> o_states == 8'h04 + {8'($past(i_wait_n)) + 8'h02, 1'b0})
    else $error("external word wait wrong");

  AST_DIR_SHORT: assert property ( // RULE_08
    take && i_op == IDSE_OP_STEP_DOWN_DIR && i_loc == IDSE_LOC_PERIPH && i_dir_short
    |=> o_states == 8'h04)
    else $error("short direct periph wrong");

  AST_SHL_BYTE: assert property ( // RULE_09
    take && i_op == IDSE_OP_SHIFT_LEFT && i_width == IDSE_W_BYTE && i_src_mode
    |=> ##1 o_done && o_carry_upd && o_result[7:0] == {$past(i_operand[6:0], 2), 1'b0}
      && o_carry_flag == $past(i_operand[7], 2))
    else $error("byte left shift wrong");

  AST_SHL_WORD: assert property ( // RULE_10
    take && i_op == IDSE_OP_SHIFT_LEFT && i_width == IDSE_W_WORD && !i_src_mode
    |=> o_bytes == 3'h3 ##2 o_done && o_carry_flag == $past(i_operand[15], 3)
      && o_result[15:0] == {$past(i_operand[14:0], 3), 1'b0})
    else $error("word left shift wrong");

  AST_SRA_BYTE: assert property ( // RULE_11
    take && i_op == IDSE_OP_SHIFT_RIGHT_ARITH && i_width == IDSE_W_BYTE && i_src_mode
    |=> ##1 o_done && o_carry_flag == $past(i_operand[0], 2)
      && o_result[7:0] == {$past(i_operand[7], 2), $past(i_operand[7:1], 2)})
    else $error("arith right shift wrong");

  AST_SRL_WORD: assert property ( // RULE_12
    take && i_op == IDSE_OP_SHIFT_RIGHT_LOGIC && i_width == IDSE_W_WORD && i_src_mode
    |=> ##1 o_done && o_carry_flag == $past(i_operand[0], 2)
      && o_result[15:0] == {1'b0, $past(i_operand[15:1], 2)})
    else $error("logic right shift wrong");

  AST_SWAP: assert property ( // RULE_13
    take && i_op == IDSE_OP_SWAP_NIBBLE
    |=> o_bytes == 3'h1 ##1 !o_done ##1 o_done && !o_carry_upd
      && o_result[7:0] == {$past(i_operand[3:0], 3), $past(i_operand[7:4], 3)})
    else $error("nibble swap wrong");

  AST_TOTAL: assert property ( // RULE_14
    o_done |-> h_cyc_ff == o_states)
    else $error("done not after total states");

  COV_EXT_WORD: cover property (take && i_loc == IDSE_LOC_EXT && i_width == IDSE_W_WORD);
  COV_SHIFT: cover property (o_done && o_carry_upd && o_carry_flag);
  COV_BACK2BACK: cover property (o_done && take);

endmodule // idse_exec

`default_nettype wire

//--- rtl/idse_pkg.sv
// types of the step/shift executor
package idse_pkg;

  typedef enum logic [3:0] {
    IDSE_OP_STEP_UP_REG       = 4'h0,
    IDSE_OP_STEP_DOWN_REG     = 4'h1,
    IDSE_OP_STEP_UP_DIR       = 4'h2,
    IDSE_OP_STEP_DOWN_DIR     = 4'h3,
    IDSE_OP_STEP_UP_IND       = 4'h4,
    IDSE_OP_STEP_DOWN_IND     = 4'h5,
    IDSE_OP_SHIFT_LEFT        = 4'h6,
    IDSE_OP_SHIFT_RIGHT_ARITH = 4'h7,
    IDSE_OP_SHIFT_RIGHT_LOGIC = 4'h8,
    IDSE_OP_SWAP_NIBBLE       = 4'h9
  } idse_op_t;

  typedef enum logic [1:0] {
    IDSE_W_BYTE  = 2'h0,
    IDSE_W_WORD  = 2'h1,
    IDSE_W_DWORD = 2'h2
  } idse_width_t;

  typedef enum logic [1:0] {
    IDSE_LOC_RAM    = 2'h0,
    IDSE_LOC_IO     = 2'h1,
    IDSE_LOC_PERIPH = 2'h2,
    IDSE_LOC_EXT    = 2'h3
  } idse_loc_t;

  typedef enum logic [1:0] {
    IDSE_ST_IDLE = 2'b01,
    IDSE_ST_RUN  = 2'b10
  } idse_state_t;

  typedef struct packed {
    idse_state_t state;
    logic [7:0]  cnt;
    idse_op_t    op;
    idse_width_t width;
    logic [1:0]  step_sel;
    logic [31:0] opnd;
    logic [2:0]  bytes;
    logic [7:0]  states;
    logic [31:0] result;
    logic        carry;
    logic        carry_upd;
    logic        done;
  } idse_exec_st_t;

endpackage

//--- rtl/idse_regs.svh
// timing counts, instruction lengths and encodings of the step/shift executor
`ifndef IDSE_REGS_SVH
`define IDSE_REGS_SVH

// ==========================================================
// short immediate select (0 selects a step of one)
`define IDSE_STEP_SEL_2    2'h1
`define IDSE_STEP_SEL_4    2'h2

// ==========================================================
// register step and shift forms
`define IDSE_B_REG_BIN     3'h3
`define IDSE_B_REG_SRC     3'h2
`define IDSE_S_REG_BIN     8'h02
`define IDSE_S_REG_SRC     8'h01
`define IDSE_S_DUP_BIN     8'h04
`define IDSE_S_DUP_SRC     8'h03
`define IDSE_S_DDN_BIN     8'h05
`define IDSE_S_DDN_SRC     8'h04

// ==========================================================
// memory step forms and nibble swap
`define IDSE_B_DIR         3'h2
`define IDSE_S_DIR         8'h02
`define IDSE_B_IND_BIN     3'h1
`define IDSE_B_IND_SRC     3'h2
`define IDSE_S_IND_BIN     8'h03
`define IDSE_S_IND_SRC     8'h04
`define IDSE_B_SWAP        3'h1
`define IDSE_S_SWAP        8'h02

// ==========================================================
// extra states by operand location
`define IDSE_ADD_IO_LONG   8'h02
`define IDSE_ADD_PER_LONG  8'h03
`define IDSE_ADD_IO_SHORT  8'h01
`define IDSE_ADD_PER_SHORT 8'h02
`define IDSE_EXT_BASE      8'h02

`endif
